/* File: nopg_pkg.sv */
/*
 package of the non-overlap pulse pattern block: register map,
 field positions, reset values and timer constants.
 assumes an axi4-lite master with 32-bit data on the same clock.
*/
package nopg_pkg;
   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_ENABLE  = 8'h00; // next_data_enable
   localparam logic [7:0] REG_STAGED  = 8'h04; // staged_output_data
   localparam logic [7:0] REG_LATCH   = 8'h08; // output_latch
   localparam logic [7:0] REG_TRIGSEL = 8'h0c; // trigger_select_reg
   localparam logic [7:0] REG_MODE    = 8'h10; // non_overlap_select
   localparam logic [7:0] REG_TSTART  = 8'h14; // timer_start_reg
   localparam logic [7:0] REG_CMPA    = 8'h18;
   localparam logic [7:0] REG_CMPB    = 8'h1c;
   localparam logic [7:0] REG_COUNT   = 8'h20; // channel_counter
   localparam logic [7:0] REG_MSTOP   = 8'h24; // module_stop_ctrl
   localparam logic [7:0] REG_STATUS  = 8'h28;
   // ----------------------------------------------------------------
   // fields
   // ----------------------------------------------------------------
   localparam int RUN_BIT      = 0;  // counter_run_bit
   localparam int MSTOP_TMR    = 0;
   localparam int MSTOP_PAT    = 1;
   localparam int TRIGSEL_W    = 2;
   localparam int CH_COUNT     = 4;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
   localparam logic [31:0] RST_STAGED = 32'h0000_0000;
   localparam logic [31:0] RST_LATCH  = 32'h0000_0000;
   localparam logic [15:0] RST_CMPA   = 16'h01f3;
   localparam logic [15:0] RST_CMPB   = 16'h03e7;
   localparam logic [1:0]  RST_MSTOP  = 2'h3;
   // ----------------------------------------------------------------
   // axi responses
   // ----------------------------------------------------------------
   localparam logic [1:0]  RESP_OKAY   = 2'b00;
   localparam logic [1:0]  RESP_SLVERR = 2'b10;
   // ----------------------------------------------------------------
   // timer example period figures
   // ----------------------------------------------------------------
   localparam int CLK_MHZ       = 200;
   localparam int CMPA_US       = 20;
   localparam int CMPB_US       = 40;
   localparam int CMPA_CYCLES   = CMPA_US * CLK_MHZ;
   localparam int CMPB_CYCLES   = CMPB_US * CLK_MHZ;
   typedef enum logic [1:0] {
      NOPG_W_IDLE = 2'b00,
      NOPG_W_RESP = 2'b01
   } nopg_wst_t;
endpackage

/* File: nopg_top.sv */
/*
 non-overlap pulse pattern output: eight 4-bit groups with staged data,
 output latch, four compare timers shared by the groups and axi4-lite registers.
 assumes a single 200 mhz clock; axi master follows the standard protocol.
*/
`timescale 1ns/1ps
module nopg_top
#(
   parameter int GROUPS = 8
)(
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      pattern_out,
   output logic [31:0]      pattern_oe,
   output logic [3:0]       compare_a_request
);
   import nopg_pkg::*;
   if (GROUPS != 8) $error("only eight groups supported");
   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [31:0] enable_q, enable_d, staged_q, staged_d, latch_q, latch_d;
   logic [15:0] trigsel_q, trigsel_d;
   logic [7:0]  nov_q, nov_d;
   logic [3:0]  run_q, run_d;
   logic [1:0]  mstop_q, mstop_d;
   logic [15:0] cmpa_q [CH_COUNT], cmpa_d [CH_COUNT];
   logic [15:0] cmpb_q [CH_COUNT], cmpb_d [CH_COUNT];
   logic [15:0] cnt_q  [CH_COUNT], cnt_d  [CH_COUNT];
   logic [3:0]  ev_a, ev_b, req_d, seen_a_q, seen_a_d;
   logic        awr_q, awr_d, wr_q, wr_d, bv_q, bv_d, rv_q, rv_d, do_wr, wr_ok;
   logic [7:0]  awa_q, awa_d;
   logic [31:0] wd_q, wd_d;
   logic [3:0]  ws_q, ws_d;
   logic [1:0]  br_q, br_d, rr_q, rr_d;
   logic [31:0] rd_q, rd_d;
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) r[8*i +: 8] = nw[8*i +: 8];
      end
      return r;
   endfunction
   function automatic logic map_ok(input logic [7:0] a);
      map_ok = (a[1:0] == 2'b00) && (a <= REG_STATUS);
   endfunction
   // ----------------------------------------------------------------
   // axi write and read channels
   // ----------------------------------------------------------------
   always_comb begin
      awr_d = awr_q;
      awa_d = awa_q;
      wr_d  = wr_q;
      wd_d  = wd_q;
      ws_d  = ws_q;
      bv_d  = bv_q;
      br_d  = br_q;
      do_wr = 1'b0;
      wr_ok = 1'b0;
      if (s_axi_awvalid && !awr_q) begin
         awr_d = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !wr_q) begin
         wr_d = 1'b1;
         wd_d = s_axi_wdata;
         ws_d = s_axi_wstrb;
      end
      if (awr_q && wr_q && !bv_q) begin
         do_wr = 1'b1;
         wr_ok = map_ok(awa_q);
         bv_d  = 1'b1;
         br_d  = wr_ok ? RESP_OKAY : RESP_SLVERR;
         awr_d = 1'b0;
         wr_d  = 1'b0;
      end
      if (bv_q && s_axi_bready) bv_d = 1'b0;
   end
   always_comb begin
      rv_d = rv_q;
      rd_d = rd_q;
      rr_d = rr_q;
      if (rv_q && s_axi_rready) rv_d = 1'b0;
      if (s_axi_arvalid && !rv_q) begin
         rv_d = 1'b1;
         rr_d = map_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         unique case (s_axi_araddr)
            REG_ENABLE:  rd_d = enable_q;
            REG_STAGED:  rd_d = staged_q;
            REG_LATCH:   rd_d = latch_q;
            REG_TRIGSEL: rd_d = {16'h0000, trigsel_q};
            REG_MODE:    rd_d = {24'h000000, nov_q};
            REG_TSTART:  rd_d = {28'h0000000, run_q};
            REG_CMPA:    rd_d = {cmpa_q[1], cmpa_q[0]};
            REG_CMPB:    rd_d = {cmpb_q[1], cmpb_q[0]};
            REG_COUNT:   rd_d = {cnt_q[1], cnt_q[0]};
            REG_MSTOP:   rd_d = {30'h00000000, mstop_q};
            REG_STATUS:  rd_d = {28'h0000000, seen_a_q};
            default:     rd_d = 32'h0000_0000;
         endcase
      end
   end
   // ----------------------------------------------------------------
   // timer channels
   // ----------------------------------------------------------------
   always_comb begin
      for (int c = 0; c < CH_COUNT; c++) begin
         cnt_d[c] = cnt_q[c];
         ev_a[c]  = 1'b0;
         ev_b[c]  = 1'b0;
         if (run_q[c] && !mstop_q[MSTOP_TMR]) begin
            ev_a[c] = (cnt_q[c] == cmpa_q[c]);
            ev_b[c] = (cnt_q[c] == cmpb_q[c]);
            cnt_d[c] = ev_b[c] ? 16'h0000 : cnt_q[c] + 16'h0001;
         end
      end
      req_d    = ev_a;
      seen_a_d = seen_a_q | ev_a;
      if (do_wr && wr_ok && awa_q == REG_STATUS) begin
         seen_a_d = (seen_a_q & ~wd_q[3:0]) | ev_a;
      end
   end
   // ----------------------------------------------------------------
   // pattern groups
   // ----------------------------------------------------------------
   always_comb begin
      logic [1:0] s;
      logic       ga, gb;
      s  = 2'b00;
      ga = 1'b0;
      gb = 1'b0;
      latch_d = latch_q;
      // triggers use staged_q before any same-cycle write
      for (int g = 0; g < 8; g++) begin
         s  = trigsel_q[2*g +: 2];
         ga = ev_a[s];
         gb = ev_b[s];
         for (int b = 0; b < 4; b++) begin
            if (!mstop_q[MSTOP_PAT] && enable_q[4*g+b]) begin
               if (nov_q[g]) begin
                  if (ga) latch_d[4*g+b] = staged_q[4*g+b];
                  else if (gb && !staged_q[4*g+b])
                     latch_d[4*g+b] = 1'b0;
               end else if (ga || gb) begin
                  latch_d[4*g+b] = staged_q[4*g+b];
               end
            end
         end
      end
      enable_d  = enable_q;
      staged_d  = staged_q;
      trigsel_d = trigsel_q;
      nov_d     = nov_q;
      run_d     = run_q;
      mstop_d   = mstop_q;
      for (int c = 0; c < CH_COUNT; c++) begin
         cmpa_d[c] = cmpa_q[c];
         cmpb_d[c] = cmpb_q[c];
      end
      if (do_wr && wr_ok) begin
         unique case (awa_q)
            REG_ENABLE:  enable_d = merge(enable_q, wd_q, ws_q);
            REG_STAGED:  staged_d = merge(staged_q, wd_q, ws_q);
            REG_LATCH:   latch_d  = merge(latch_q, wd_q, ws_q);
            REG_TRIGSEL: trigsel_d = wd_q[15:0];
            REG_MODE:    nov_d = wd_q[7:0];
            REG_TSTART:  run_d = wd_q[3:0];
            REG_CMPA:    cmpa_d[wd_q[31:30]] = wd_q[15:0];
            REG_CMPB:    cmpb_d[wd_q[31:30]] = wd_q[15:0];
            REG_MSTOP:   mstop_d = wd_q[1:0];
            default:     ;
         endcase
      end
   end
   // ----------------------------------------------------------------
   // state registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         enable_q  <= RST_ENABLE;
         staged_q  <= RST_STAGED;
         latch_q   <= RST_LATCH;
         trigsel_q <= 16'h0000;
         nov_q     <= 8'h00;
         run_q     <= 4'h0;
         mstop_q   <= RST_MSTOP;
         seen_a_q  <= 4'h0;
         for (int c = 0; c < CH_COUNT; c++) begin
            cmpa_q[c] <= RST_CMPA;
            cmpb_q[c] <= RST_CMPB;
            cnt_q[c]  <= 16'h0000;
         end
         awr_q <= 1'b0;
         awa_q <= 8'h00;
         wr_q  <= 1'b0;
         wd_q  <= 32'h0000_0000;
         ws_q  <= 4'h0;
         bv_q  <= 1'b0;
         br_q  <= 2'b00;
         rv_q  <= 1'b0;
         rd_q  <= 32'h0000_0000;
         rr_q  <= 2'b00;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_arready <= 1'b1;
         compare_a_request <= 4'h0;
         pattern_out <= 32'h0000_0000;
         pattern_oe  <= 32'h0000_0000;
      end else begin
         enable_q  <= enable_d;
         staged_q  <= staged_d;
         latch_q   <= latch_d;
         trigsel_q <= trigsel_d;
         nov_q     <= nov_d;
         run_q     <= run_d;
         mstop_q   <= mstop_d;
         seen_a_q  <= seen_a_d;
         cmpa_q    <= cmpa_d;
         cmpb_q    <= cmpb_d;
         cnt_q     <= cnt_d;
         awr_q <= awr_d;
         awa_q <= awa_d;
         wr_q  <= wr_d;
         wd_q  <= wd_d;
         ws_q  <= ws_d;
         bv_q  <= bv_d;
         br_q  <= br_d;
         rv_q  <= rv_d;
         rd_q  <= rd_d;
         rr_q  <= rr_d;
         s_axi_awready <= !awr_d;
         s_axi_wready  <= !wr_d;
         s_axi_arready <= !rv_d;
         compare_a_request <= req_d;
         pattern_out <= latch_d;
         pattern_oe  <= enable_d;
      end
   end
   assign s_axi_bvalid  = bv_q;
   assign s_axi_bresp   = br_q;
   assign s_axi_rvalid  = rv_q;
   assign s_axi_rdata   = rd_q;
   assign s_axi_rresp   = rr_q;
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_pin_follows_latch;
      @(posedge ref_clk) disable iff (sys_rst) pattern_out == latch_q;
   endproperty
   a_pin_follows_latch: assert property (p_pin_follows_latch)
      else $error("pin differs from latch");
   property p_oe_follows_enable;
      @(posedge ref_clk) disable iff (sys_rst) pattern_oe == enable_q;
   endproperty
   a_oe_follows_enable: assert property (p_oe_follows_enable)
      else $error("enable differs from oe");
   property p_disabled_hold;
      @(posedge ref_clk) disable iff (sys_rst)
         !(do_wr && awa_q == REG_LATCH) |=>
            ((latch_q ^ $past(latch_q)) & ~$past(enable_q)) == 32'h0;
   endproperty
   a_disabled_hold: assert property (p_disabled_hold)
      else $error("disabled bit changed");
   property p_req_on_a;
      @(posedge ref_clk) disable iff (sys_rst)
         ev_a[0] |=> compare_a_request[0];
   endproperty
   a_req_on_a: assert property (p_req_on_a)
      else $error("no request after compare a");
   property p_stop_count;
      @(posedge ref_clk) disable iff (sys_rst)
         !run_q[0] |=> cnt_q[0] == $past(cnt_q[0]);
   endproperty
   a_stop_count: assert property (p_stop_count)
      else $error("counter moved while stopped");
   property p_mstop_freeze;
      @(posedge ref_clk) disable iff (sys_rst)
         mstop_q[MSTOP_TMR] |-> !ev_a[0] && !ev_b[0];
   endproperty
   a_mstop_freeze: assert property (p_mstop_freeze)
      else $error("event while timer stopped");
   property p_nov_b_no_rise;
      @(posedge ref_clk) disable iff (sys_rst)
         (nov_q[4] && !ev_a[trigsel_q[9:8]] && !do_wr) |=>
            (latch_q[19:16] & ~$past(latch_q[19:16])) == 4'h0;
   endproperty
   a_nov_b_no_rise: assert property (p_nov_b_no_rise)
      else $error("bit rose without compare a");
   property p_nov_a_copy;
      @(posedge ref_clk) disable iff (sys_rst)
         (nov_q[4] && ev_a[trigsel_q[9:8]] && enable_q[16]
          && !mstop_q[MSTOP_PAT] && !do_wr) |=>
            latch_q[16] == $past(staged_q[16]);
   endproperty
   a_nov_a_copy: assert property (p_nov_a_copy)
      else $error("compare a did not copy");
endmodule

/* File: nopg_refill_model.sv */
/*
 refill model: on each compare a request writes the next table word
 into the staged register over the axi4-lite write channels.
 assumes nopg_top on ref_clk and a bench that hands it the bus.
*/
`timescale 1ns/1ps
module nopg_refill_model (
   input  wire logic        ref_clk,
   input  wire logic        active,
   input  wire logic        trig,
   input  wire logic        awready,
   input  wire logic        wready,
   input  wire logic        bvalid,
   output logic [7:0]       awaddr,
   output logic             awvalid,
   output logic [31:0]      wdata,
   output logic             wvalid,
   output logic             bready
);
   import nopg_pkg::*;
   logic [3:0] idx;
   bit         aw_ok;
   bit         w_ok;
   bit         b_ok;
   // ----------------------------------------------------------------
   // one table write per request, table wraps after sixteen
   // ----------------------------------------------------------------
   initial begin
      idx     = 4'h0;
      awaddr  = REG_STAGED;
      awvalid = 1'b0;
      wdata   = 32'h0;
      wvalid  = 1'b0;
      bready  = 1'b0;
      forever begin
         @(posedge ref_clk);
         if (active && trig) begin
            awvalid <= 1'b1;
            wvalid  <= 1'b1;
            bready  <= 1'b1;
            wdata   <= {8{idx}};
            aw_ok = 1'b0;
            w_ok  = 1'b0;
            b_ok  = 1'b0;
            while (!b_ok) begin
               @(posedge ref_clk);
               if (!aw_ok && awready) begin
                  aw_ok = 1'b1;
                  awvalid <= 1'b0;
               end
               if (!w_ok && wready) begin
                  w_ok = 1'b1;
                  wvalid <= 1'b0;
               end
               if (bvalid) begin
                  b_ok = 1'b1;
                  bready <= 1'b0;
               end
            end
            idx <= idx + 4'h1;
         end
      end
   end
endmodule

/* File: nopg_top_tb.sv */
/*
 testbench of nopg_top: register access, reset values, module stop,
 and a non-overlap pattern run fed by the refill model.
 assumes nopg_pkg and nopg_refill_model compiled before it.
*/
`timescale 1ns/1ps
module nopg_top_tb;
   import nopg_pkg::*;
   localparam logic [31:0] EN   = 32'h00ff_0000;
   localparam logic [31:0] LAT0 = 32'h5a5a_5a5a;
   localparam logic [31:0] G4   = 32'h000f_0000;
   logic        ref_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        sel = 1'b0;
   logic [7:0]  t_awaddr = 8'h0, m_awaddr, awaddr, araddr = 8'h0;
   logic        t_awvalid = 1'b0, m_awvalid, awvalid, awready;
   logic [31:0] t_wdata = 32'h0, m_wdata, wdata, rdata;
   logic        t_wvalid = 1'b0, m_wvalid, wvalid, wready;
   logic        t_bready = 1'b0, m_bready, bready, bvalid;
   logic [1:0]  bresp, rresp, r;
   logic        arvalid = 1'b0, arready, rvalid, rready = 1'b0;
   logic [31:0] pattern_out, pattern_oe, d, d2, pv, nw;
   logic [3:0]  compare_a_request;
   logic [7:0]  ra [7];
   logic [31:0] rv [7];
   int          n_mismatch = 0;
   int          n_tests = 0;
   assign awaddr  = sel ? m_awaddr  : t_awaddr;
   assign awvalid = sel ? m_awvalid : t_awvalid;
   assign wdata   = sel ? m_wdata   : t_wdata;
   assign wvalid  = sel ? m_wvalid  : t_wvalid;
   assign bready  = sel ? m_bready  : t_bready;
   always #2.5 ref_clk = ~ref_clk;
   nopg_top nopg_top_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .pattern_out(pattern_out),
      .pattern_oe(pattern_oe), .compare_a_request(compare_a_request));
   nopg_refill_model nopg_refill_model_inst (.ref_clk(ref_clk),
      .active(sel), .trig(compare_a_request[0]), .awready(awready),
      .wready(wready), .bvalid(bvalid), .awaddr(m_awaddr),
      .awvalid(m_awvalid), .wdata(m_wdata), .wvalid(m_wvalid),
      .bready(m_bready));
   // ----------------------------------------------------------------
   // bus tasks and compares
   // ----------------------------------------------------------------
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                         output logic [1:0] rs);
      bit aw_ok, w_ok, b_ok;
      @(posedge ref_clk);
      t_awaddr <= a; t_awvalid <= 1'b1; t_wdata <= v; t_wvalid <= 1'b1;
      t_bready <= 1'b1;
      aw_ok = 1'b0; w_ok = 1'b0; b_ok = 1'b0;
      while (!b_ok) begin
         @(posedge ref_clk);
         if (!aw_ok && awready) begin aw_ok = 1'b1; t_awvalid <= 1'b0; end
         if (!w_ok && wready) begin w_ok = 1'b1; t_wvalid <= 1'b0; end
         if (bvalid) begin b_ok = 1'b1; rs = bresp; t_bready <= 1'b0; end
      end
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
                         output logic [1:0] rs);
      bit ar_ok, r_ok;
      @(posedge ref_clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      ar_ok = 1'b0; r_ok = 1'b0;
      while (!r_ok) begin
         @(posedge ref_clk);
         if (!ar_ok && arready) begin ar_ok = 1'b1; arvalid <= 1'b0; end
         if (rvalid) begin
            r_ok = 1'b1;
            v = rdata;
            rs = rresp;
            rready <= 1'b0;
         end
      end
   endtask
   task automatic chk_word(input string nm, input logic [31:0] e,
                           input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_resp(input string nm, input logic [1:0] e,
                           input logic [1:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic give_verdict;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   function automatic logic [31:0] exp_pin(input logic [31:0] v);
      return (LAT0 & ~EN) | (v & EN);
   endfunction
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      ra = '{REG_ENABLE, REG_STAGED, REG_LATCH, REG_COUNT, REG_MSTOP,
             REG_CMPA, REG_CMPB};
      rv = '{RST_ENABLE, RST_STAGED, RST_LATCH, 32'h0, {30'h0, RST_MSTOP},
             {2{RST_CMPA}}, {2{RST_CMPB}}};
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      chk_word("latch at reset", 32'h0, pattern_out);
      for (int i = 0; i < 7; i++) begin
         axi_rd(ra[i], d, r);
         chk_word("reset value", rv[i], d);
      end
      axi_rd(8'h2c, d, r);
      chk_resp("unmapped read", RESP_SLVERR, r);
      chk_word("unmapped data", 32'h0, d);
      axi_wr(8'h40, 32'hffff_ffff, r);
      chk_resp("unmapped write", RESP_SLVERR, r);
      axi_wr(REG_LATCH, LAT0, r);
      chk_resp("latch write", RESP_OKAY, r);
      axi_wr(REG_ENABLE, EN, r);
      axi_wr(REG_MODE, 32'h10, r);
      @(posedge ref_clk);
      chk_word("pins before trigger", LAT0, pattern_out);
      chk_word("pin drive", EN, pattern_oe);
      axi_wr(REG_TSTART, 32'h1, r);
      axi_rd(REG_COUNT, d, r);
      chk_word("counter in stop", 32'h0, d);
      axi_wr(REG_TSTART, 32'h0, r);
      axi_wr(REG_MSTOP, 32'h0, r);
      axi_rd(REG_COUNT, d, r);
      chk_word("counter not run", 32'h0, d);
      axi_wr(REG_TSTART, 32'h1, r);
      sel <= 1'b1;
      pv = 32'h0;
      for (int i = 0; i < 18; i++) begin
         nw = {8{i[3:0]}};
         while (compare_a_request[0] !== 1'b1) @(posedge ref_clk);
         @(posedge ref_clk);
         chk_word("req pulse", 32'h0, {28'h0, compare_a_request});
         repeat (249) @(posedge ref_clk);
         chk_word("pins after a", exp_pin(pv),
                  pattern_out);
         repeat (500) @(posedge ref_clk);
         d = exp_pin((nw & ~G4) | (pv & nw & G4));
         chk_word("pins in margin", d,
                  pattern_out);
         pv = nw;
      end
      sel <= 1'b0;
      // group 4 moved to idle channel 1, group 5 stays on channel 0
      axi_wr(REG_TRIGSEL, 32'h0000_0100, r);
      axi_wr(REG_STAGED, 32'h00ff_0000, r);
      while (compare_a_request[0] !== 1'b1) @(posedge ref_clk);
      repeat (2) @(posedge ref_clk);
      d = exp_pin(32'h00f0_0000);
      chk_word("channel select", d, pattern_out);
      axi_wr(REG_TSTART, 32'h0, r);
      axi_rd(REG_COUNT, d, r);
      repeat (20) @(posedge ref_clk);
      axi_rd(REG_COUNT, d2, r);
      chk_word("halted counter", d, d2);
      axi_rd(REG_STATUS, d, r);
      chk_word("compare a status", 32'h1, d & 32'h1);
      give_verdict();
   end
   initial begin
      repeat (40000) @(posedge ref_clk);
      n_mismatch++;
      give_verdict();
   end
endmodule
